// *** src/acc_pkg.sv ***
// Constants, carrier structs and state types for the converter control block
package acc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // Product of the external R and C on the oscillator pins
  localparam int OSC_RC_NS = 1500;
  localparam int OSC_PERIOD_NS = (OSC_RC_NS * 11) / 10;
  localparam int OSC_CYCLES = (OSC_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [6:0] OSC_LAST = 7'(OSC_CYCLES - 1);
  localparam logic [3:0] TICKS_PER_BIT_LAST = 4'h7;

  // ----------------------------------------------------------------
  // Code layout
  // ----------------------------------------------------------------
  localparam int CODE_W = 8;
  localparam int CODE_STEPS = 256;
  localparam logic [2:0] MSB_INDEX = 3'h7;
  localparam logic [7:0] MSB_TRIAL = 8'h80;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [9:0] HALF_STEP_BIAS = 10'h001;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic clk_in;
  } acc_pins_t;

  typedef struct packed {
    logic [CODE_W-1:0] data;
    logic data_oe;
  } acc_bus_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_HOLD, SEQ_CONV} acc_seq_t;

  typedef struct packed {
    acc_pins_t meta;
    acc_pins_t sync;
    logic clk_prev;
    acc_seq_t seq;
    logic [6:0] osc_cnt;
    logic [CODE_W-1:0] latch;
    logic done_n;
    acc_bus_t bus;
  } acc_ctl_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [2:0] bit_idx;
    logic [3:0] ticks;
    logic [CODE_W-1:0] trial;
    logic [8:0] held;
  } acc_sar_state_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam acc_pins_t PINS_IDLE = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, clk_in: 1'b0};
  localparam acc_ctl_state_t CTL_RESET = '{meta: PINS_IDLE, sync: PINS_IDLE, clk_prev: 1'b0, seq: SEQ_IDLE,
    osc_cnt: 7'h00, latch: CODE_RESET, done_n: 1'b1, bus: '{data: CODE_RESET, data_oe: 1'b0}};
  localparam acc_sar_state_t SAR_RESET = '{busy: 1'b0, done: 1'b0, bit_idx: 3'h0, ticks: 4'h0,
    trial: CODE_RESET, held: 9'h000};

endpackage

// *** src/acc_sar.sv ***
// Successive approximation sequencer for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acc_sar (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic tick,
  input wire logic abort,
  input wire logic go,
  input wire logic [8:0] vin_half,
  output logic busy,
  output logic done,
  output logic [acc_pkg::CODE_W-1:0] code
);
  import acc_pkg::*;

  acc_sar_state_t s;
  acc_sar_state_t next_s;
  logic keep;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    // Threshold sits half a step below each code
    keep = ({1'b0, s.held} + HALF_STEP_BIAS) >= {1'b0, s.trial, 1'b0};
    if (abort) begin
      next_s.busy = 1'b0;
      next_s.ticks = 4'h0;
    end else if (go) begin
      next_s.busy = 1'b1;
      next_s.bit_idx = MSB_INDEX;
      next_s.ticks = 4'h0;
      next_s.trial = MSB_TRIAL;
      next_s.held = vin_half;
    end else if (s.busy && tick) begin
      if (s.ticks != TICKS_PER_BIT_LAST) begin
        next_s.ticks = s.ticks + 4'h1;
      end else begin
        next_s.ticks = 4'h0;
        if (!keep) begin
          next_s.trial = s.trial & ~(8'h01 << s.bit_idx);
        end
        if (s.bit_idx == 3'h0) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end else begin
          next_s.bit_idx = s.bit_idx - 3'h1;
          next_s.trial = next_s.trial | (8'h01 << (s.bit_idx - 3'h1));
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= SAR_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
  assign code = s.trial;

endmodule
`default_nettype wire

// *** src/acc_top.sv ***
// Host-side control of the successive approximation converter
`timescale 1ns/1ns
`default_nettype none
module acc_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire acc_pkg::acc_pins_t pins,
  input wire logic clk_src_ext,
  input wire logic [8:0] vin_half,
  output logic conversion_done_n,
  output acc_pkg::acc_bus_t bus
);
  import acc_pkg::*;

  acc_ctl_state_t s;
  acc_ctl_state_t next_s;
  logic start_low;
  logic rd_low;
  logic tick;
  logic go;
  logic sar_busy;
  logic sar_done;
  logic [CODE_W-1:0] sar_code;

  // ----------------------------------------------------------------
  // Sequencer core
  // ----------------------------------------------------------------
  acc_sar u_sar (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .tick(tick),
    .abort(start_low),
    .go(go),
    .vin_half(vin_half),
    .busy(sar_busy),
    .done(sar_done),
    .code(sar_code)
  );

  // ----------------------------------------------------------------
  // Control logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Pins are asynchronous; only the second stage is looked at
    next_s.meta = pins;
    next_s.sync = s.meta;
    start_low = !s.sync.cs_n && !s.sync.wr_n;
    rd_low = !s.sync.cs_n && !s.sync.rd_n;

    // Clock from pin edge or internal oscillator
    next_s.clk_prev = s.sync.clk_in;
    next_s.osc_cnt = (s.osc_cnt == OSC_LAST) ? 7'h00 : s.osc_cnt + 7'h01;
    tick = clk_src_ext ? (s.sync.clk_in && !s.clk_prev) : (s.osc_cnt == OSC_LAST);

    // Start taken on release of either strobe
    go = (s.seq == SEQ_HOLD) && !start_low;
    unique case (s.seq)
      SEQ_IDLE: begin
        if (start_low) begin
          next_s.seq = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (!start_low) begin
          next_s.seq = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (start_low) begin
          next_s.seq = SEQ_HOLD;
        end else if (sar_done || !sar_busy) begin
          next_s.seq = SEQ_IDLE;
        end
      end
    endcase

    // Completion loads latch, done goes low
    if (sar_done && !start_low) begin
      next_s.latch = sar_code;
      next_s.done_n = 1'b0;
    end else if (start_low || rd_low) begin
      // Done held high through a restart
      // Write tied to done releases itself here
      next_s.done_n = 1'b1;
    end

    // Drive data only during a read
    next_s.bus.data_oe = rd_low;
    next_s.bus.data = rd_low ? s.latch : CODE_RESET;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= CTL_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign conversion_done_n = s.done_n;
  assign bus = s.bus;

endmodule
`default_nettype wire

// *** dv/acc_checker.sv ***
// Port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acc_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire acc_pkg::acc_pins_t pins,
  input wire logic clk_src_ext,
  input wire logic conversion_done_n,
  input wire acc_pkg::acc_bus_t bus
);
  import acc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Strobes as the logic sees them, three edges before the outputs react
  wire logic rd = !pins.cs_n && !pins.rd_n;
  wire logic st = !pins.cs_n && !pins.wr_n;
  a_read_drives: assert property (rd [*4] |-> bus.data_oe) else $error("no read drive");
  a_bus_freed: assert property ((!rd) [*4] |-> !bus.data_oe) else $error("late release");
  a_oe_cause: assert property (bus.data_oe |-> $past(rd, 3)) else $error("stray drive");
  a_idle_zero: assert property (!bus.data_oe |-> bus.data == 8'h00) else $error("idle data");
  a_start_high: assert property (st [*4] |-> conversion_done_n) else $error("done in start");
  a_restart_end: assert property ($fell(st) && clk_src_ext |-> conversion_done_n [*8] ##[1:600]
    (!conversion_done_n || st || rd)) else $error("late result");
  a_reset_idle: assert property ($past(sys_rst) |-> conversion_done_n && !bus.data_oe) else $error("reset");
endmodule
bind acc_top acc_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins), .clk_src_ext(clk_src_ext),
  .conversion_done_n(conversion_done_n), .bus(bus));
`default_nettype wire

// *** dv/acc_host.sv ***
// Host bus model with free-running conversion clock
`timescale 1ns/1ns
`default_nettype none
module acc_host (
  input wire logic clk_sys,
  input wire logic [1:0] cmd,
  input wire logic free,
  input wire logic done_n,
  output var acc_pkg::acc_pins_t pins
);
  logic [2:0] hold = 3'h0;
  logic [1:0] kind = 2'h0;
  logic [2:0] ck = 3'h0;
  always @(negedge clk_sys) begin
    ck <= ck + 3'h1;
    hold <= hold != 3'h0 ? hold - 3'h1 : (cmd != 2'h0 ? 3'h4 : 3'h0);
    kind <= hold != 3'h0 ? kind : cmd;
  end
  // command 3 pulls the joined node low as the power-up kick
  wire logic kick = hold != 3'h0 && kind == 2'h3;
  // free-run: select grounded, write joined to done
  assign pins = free ? acc_pkg::acc_pins_t'{cs_n: 1'b0, wr_n: done_n && !kick, rd_n: 1'b1, clk_in: ck[2]} :
    acc_pkg::acc_pins_t'{cs_n: hold == 3'h0, wr_n: hold == 3'h0 || kind != 2'h1,
    rd_n: hold == 3'h0 || kind != 2'h2, clk_in: ck[2]};
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import acc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ext = 1'b1;
  logic [8:0] vin = 9'h000;
  logic [1:0] cmd = 2'h0;
  logic free = 1'b0;
  acc_pins_t pins;
  logic done_n;
  acc_bus_t bus;
  int err_count = 0;
  int compares = 0;
  int runs = 0;
  logic last = 1'b1;
  always #10 clk_sys = ~clk_sys;
  acc_host u_host (.clk_sys(clk_sys), .cmd(cmd), .free(free), .done_n(done_n), .pins(pins));
  acc_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .pins(pins), .clk_src_ext(ext), .vin_half(vin),
    .conversion_done_n(done_n), .bus(bus));
  function automatic logic [7:0] code_of(input logic [8:0] v);
    return v > 9'h1FC ? 8'hFF : 8'((v + 9'h001) >> 1);
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic op(input logic [1:0] c);
    @(negedge clk_sys);
    cmd <= c;
    @(negedge clk_sys);
    cmd <= 2'h0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic rd_chk(input logic [7:0] e);
    op(2'h2);
    cmp("data_oe", 8'h01, {7'h00, bus.data_oe});
    cmp("data", e, bus.data);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic conv(input logic [8:0] v);
    int i;
    vin = v;
    op(2'h1);
    for (i = 0; i < 8000 && done_n !== 1'b0; i++)
      @(negedge clk_sys);
    cmp("done_n", 8'h00, {7'h00, done_n});
    if (i == 8000)
      wrap_up();
    rd_chk(code_of(v));
  endtask
  initial begin
    void'($urandom(4189));
    repeat (4) @(negedge clk_sys);
    sys_rst <= 1'b0;
    for (int j = 0; j < 6; j++)
      conv(j < 3 ? 9'(j) : 9'(505 + j));
    repeat (16)
      conv(9'($urandom));
    $display("test codes done");
    ext = 1'b0;
    conv(9'h0AB);
    ext = 1'b1;
    $display("test clock done");
    // Second start lands mid-conversion, so the latch must still hold the old code
    repeat (2) begin
      vin = 9'($urandom);
      op(2'h1);
      repeat (400) @(negedge clk_sys);
      cmp("done_n", 8'h01, {7'h00, done_n});
      rd_chk(code_of(9'h0AB));
    end
    conv(vin);
    $display("test restart done");
    // Free-running loop: one kick, then every completion retriggers itself
    vin = 9'($urandom);
    free = 1'b1;
    op(2'h3);
    for (int k = 0; k < 2000 && runs < 2; k++) begin
      @(negedge clk_sys);
      if (!done_n && last)
        runs++;
      last = done_n;
    end
    free = 1'b0;
    cmp("free_runs", 8'h02, 8'(runs));
    cmp("done_n", 8'h00, {7'h00, done_n});
    rd_chk(code_of(vin));
    $display("test free run done");
    // Reset lands in a read and a conversion; neither may leave a trace
    op(2'h1);
    repeat (100) @(negedge clk_sys);
    op(2'h2);
    sys_rst <= 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst <= 1'b0;
    repeat (600) @(negedge clk_sys);
    cmp("done_n", 8'h01, {7'h00, done_n});
    rd_chk(CODE_RESET);
    $display("test reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
